/* File: rtl/sac_device.sv */
// converter end: period counter, bit tests, output latches and ready flag
`timescale 1ns/100ps
`default_nettype none
`include "sac_map.svh"

module sac_device (
	// clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  resetn_i,
	// configuration and analog side
	input  wire sac_pkg::sac_clk_mode_e clk_mode_i,
	input  wire logic                  comparator_high_i,
	// link
	sac_if.dev                         link,
	// analog switch controls, oscillator run and period number
	output logic                       track_input_o,
	output logic                       balance_o,
	output logic [9:0]                 cap_to_refp_o,
	output logic                       conv_clk_run_o,
	output logic [3:0]                 period_o
);
	import sac_pkg::*;

	// ************************************************
	// start and output enable synchronisers: pins from outside the domain
	// ************************************************
	logic [2:0] start_sync_ff;
	logic       start_low_ff;
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			start_sync_ff <= 3'h7;
			start_low_ff  <= 1'b0;
		end else begin
			start_sync_ff <= {start_sync_ff[1:0], link.convert_start_n};
			if (start_sync_ff[2] == start_sync_ff[1])
				start_low_ff <= ~start_sync_ff[2];
		end
	end

	logic [2:0] en_hi_ff;
	logic [2:0] en_lo_ff;
	logic       hi_on_ff;
	logic       lo_on_ff;
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			en_hi_ff <= 3'h7;
			en_lo_ff <= 3'h7;
			hi_on_ff <= 1'b0;
			lo_on_ff <= 1'b0;
		end else begin
			en_hi_ff <= {en_hi_ff[1:0], link.upper_byte_out_en_n};
			en_lo_ff <= {en_lo_ff[1:0], link.low_bits_out_en_n};
			if (en_hi_ff[2] == en_hi_ff[1])
				hi_on_ff <= ~en_hi_ff[2];
			if (en_lo_ff[2] == en_lo_ff[1])
				lo_on_ff <= ~en_lo_ff[2];
		end
	end

	// ************************************************
	// period sequencing
	// ************************************************
	sac_period_t period_ff;
	sac_period_t nxt_period;
	logic        armed_ff;        // start seen during period one or two
	logic        rdy_ff;
	sac_data_t   sar_ff;
	sac_data_t   out_ff;
	logic        idle_p2;
	logic        advance;
	logic [3:0]  test_bit;

	// parked in period two: waits for a new start (either clock source)
	assign idle_p2  = (period_ff == 4'h2) && !armed_ff && !start_low_ff;
	assign advance  = !idle_p2;
	assign nxt_period = (period_ff == `SAC_PERIODS) ? 4'h1 : period_ff + 4'h1;
	assign test_bit = 4'(`SAC_PERIODS - period_ff);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			period_ff <= 4'h1;
			armed_ff  <= 1'b1;
		end else begin
			if (advance)
				period_ff <= nxt_period;
			if (period_ff == `SAC_PERIODS)
				armed_ff <= 1'b0;
			else if (start_low_ff && (period_ff <= 4'h2))
				armed_ff <= 1'b1;
		end
	end

	// ************************************************
	// successive approximation register
	// ************************************************
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			sar_ff <= `SAC_RESULT_RESET;
			out_ff <= `SAC_RESULT_RESET;
		end else if (period_ff == `SAC_TRACK_LAST) begin
			sar_ff <= 10'h200;
		end else if (period_ff >= `SAC_FIRST_TEST) begin
			// keep or drop the bit under test, try the next lower one
			sar_ff[test_bit] <= comparator_high_i;
			if (test_bit != 4'h0)
				sar_ff[test_bit - 4'h1] <= 1'b1;
			if (period_ff == `SAC_PERIODS) begin
				out_ff    <= {sar_ff[9:1], comparator_high_i};
			end
		end
	end

	// ************************************************
	// ready flag; clear input acts without the clock
	// ************************************************
	always_ff @(posedge mclk_i or negedge link.ready_flag_clear_n) begin
		if (!link.ready_flag_clear_n)
			rdy_ff <= 1'b0;
		else if (!resetn_i)
			rdy_ff <= 1'b0;
		else if (period_ff == `SAC_PERIODS)
			rdy_ff <= 1'b1;
		// drops as period two begins, or on the start that ends a park
		else if ((period_ff <= 4'h2) && start_low_ff)
			rdy_ff <= 1'b0;
	end

	// ************************************************
	// outputs
	// ************************************************
	logic       track_ff;
	logic [9:0] oe_ff;
	logic       run_ff;
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			track_ff <= 1'b1;
			oe_ff    <= 10'h000;
			run_ff   <= 1'b1;
		end else begin
			track_ff <= (nxt_period <= `SAC_TRACK_LAST) || idle_p2;
			oe_ff    <= {{8{hi_on_ff}}, {2{lo_on_ff}}};
			// internal oscillator halts while parked
			run_ff   <= !(idle_p2 && clk_mode_i == sac_clk_internal);
		end
	end

	assign track_input_o          = track_ff;
	assign balance_o              = track_ff;
	assign cap_to_refp_o          = sar_ff;
	assign conv_clk_run_o         = run_ff;
	assign period_o               = period_ff;
	assign link.result_ready_flag = rdy_ff;
	assign link.data_o            = out_ff;
	assign link.data_oe           = oe_ff;
endmodule : sac_device
`default_nettype wire

/* File: pkg/sac_map.svh */
// timing and field constants for the conversion sequencer
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_PERIODS       4'hd
`define SAC_TRACK_LAST    4'h3
`define SAC_FIRST_TEST    4'h4
`define SAC_DATA_W        10
`define SAC_MSB           4'h9
`define SAC_UPPER_LSB     2
`define SAC_RESULT_RESET  10'h000
`endif

/* File: pkg/sac_pkg.sv */
// types shared by both ends of the conversion sequencer
package sac_pkg;
	typedef logic [3:0] sac_period_t;
	typedef logic [9:0] sac_data_t;
	typedef enum logic {sac_clk_internal, sac_clk_external} sac_clk_mode_e;
endpackage : sac_pkg

/* File: pkg/sac_if.sv */
// link between the converter and its host
`timescale 1ns/100ps
`default_nettype none
interface sac_if;
	logic       convert_start_n;
	logic       ready_flag_clear_n;
	logic       upper_byte_out_en_n;
	logic       low_bits_out_en_n;
	logic       result_ready_flag;
	logic [9:0] data_o;
	logic [9:0] data_oe;
	logic [9:0] data_bus;
	assign data_bus = data_o;
	modport dev (
		input  convert_start_n, ready_flag_clear_n, upper_byte_out_en_n, low_bits_out_en_n,
		output result_ready_flag, data_o, data_oe
	);
	modport host (
		output convert_start_n, ready_flag_clear_n, upper_byte_out_en_n, low_bits_out_en_n,
		input  result_ready_flag, data_bus, data_oe
	);
endinterface : sac_if
`default_nettype wire

/* File: rtl/sac_host.sv */
// host end: issues starts, reads the result on ready's falling edge
`timescale 1ns/100ps
`default_nettype none
`include "sac_map.svh"
module sac_host (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             resetn_i,
	// user side
	input  wire logic             free_run_i,
	input  wire logic             start_req_i,
	input  wire logic             read_en_i,
	input  wire logic             clear_req_i,
	output logic                  result_valid_o,
	output logic [9:0]            result_o,
	// link
	sac_if.host                   link
);
	import sac_pkg::*;

	logic       rdy_ff;
	logic       start_n_ff;
	logic       clr_n_ff;
	logic       valid_ff;
	sac_data_t  res_ff;
	logic       fall;

	// flag comes from logic on this clock and may stand one cycle only,
	// so no filter; a fall caused by our own clear carries no new data
	assign fall = rdy_ff && !link.result_ready_flag && clr_n_ff;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdy_ff      <= 1'b0;
			start_n_ff  <= 1'b1;
			clr_n_ff    <= 1'b1;
			valid_ff    <= 1'b0;
			res_ff      <= `SAC_RESULT_RESET;
		end else begin
			rdy_ff     <= link.result_ready_flag;
			start_n_ff <= !(free_run_i || start_req_i);
			clr_n_ff   <= !clear_req_i;
			valid_ff   <= fall;
			if (fall)
				res_ff <= link.data_bus;
		end
	end

	assign link.convert_start_n     = start_n_ff;
	assign link.ready_flag_clear_n  = clr_n_ff;
	assign link.upper_byte_out_en_n = !read_en_i;
	assign link.low_bits_out_en_n   = !read_en_i;
	assign result_valid_o           = valid_ff;
	assign result_o                 = res_ff;
endmodule : sac_host
`default_nettype wire

/* File: testbench/sac_monitor.sv */
// concurrent checks on the link between converter and host
`timescale 1ns/100ps
`default_nettype none
module sac_monitor (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// link
	input  wire logic       convert_start_n,
	input  wire logic       ready_flag_clear_n,
	input  wire logic       upper_byte_out_en_n,
	input  wire logic       low_bits_out_en_n,
	input  wire logic       result_ready_flag,
	input  wire logic [9:0] data_o,
	input  wire logic [9:0] data_oe,
	// converter state
	input  wire logic [3:0] period_o,
	input  wire logic       track_input_o
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// six idle samples outlast the start filter
	sequence idle_s; convert_start_n [*6]; endsequence
	sequence parked_s; period_o == 4'h2 && $past(period_o) == 4'h2; endsequence
	step_up_a: assert property (period_o != 4'h2 && period_o != 4'hd |=>
		period_o == $past(period_o) + 4'h1) else $error("period did not advance");
	period_wrap_a: assert property (period_o == 4'hd |=> period_o == 4'h1)
		else $error("period 13 not followed by 1");
	track_window_a: assert property (track_input_o == (period_o <= 4'h3))
		else $error("tracking outside periods 1 to 3");
	ready_rise_a: assert property ($rose(result_ready_flag) |->
		period_o == 4'h1 && $past(period_o) == 4'hd) else $error("ready rose late");
	data_update_a: assert property ($changed(data_o) |-> $past(period_o) == 4'hd)
		else $error("data changed mid conversion");
	ready_fall_a: assert property ($fell(result_ready_flag) && ready_flag_clear_n |->
		period_o inside {[4'h2:4'h3]}) else $error("ready fell in wrong period");
	flag_clear_a: assert property (!ready_flag_clear_n |-> !result_ready_flag)
		else $error("ready high during clear");
	drive_on_a: assert property ((!upper_byte_out_en_n && !low_bits_out_en_n) [*6] |->
		data_oe == 10'h3ff) else $error("enabled bits not driven");
	drive_off_a: assert property ((upper_byte_out_en_n && low_bits_out_en_n) [*6] |->
		data_oe == 10'h000) else $error("disabled bits driven");
	park_hold_a: assert property (idle_s ##0 parked_s |=> period_o == 4'h2)
		else $error("left period 2 without start");
endmodule : sac_monitor
`default_nettype wire

/* File: testbench/sar_adc_conversion_sequencer_test.sv */
// self-checking bench joining converter and host ends
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_sequencer_test;
	import sac_pkg::*;
	logic          mclk_i    = 1'b0;
	logic          resetn_i  = 1'b0;
	sac_clk_mode_e clk_mode  = sac_clk_internal;
	logic          cmp_high  = 1'b0;
	logic          free_run  = 1'b0;
	logic          start_req = 1'b0;
	logic          read_en   = 1'b0;
	logic          clear_req = 1'b0;
	logic          valid;
	logic          run;
	logic          track;
	logic [9:0]    result;
	logic [3:0]    period;
	int            errors    = 0;
	int            checked   = 0;
	sac_if link ();
	// never stopped, so no conversion period loses its clock
	always #50 mclk_i = ~mclk_i;
	sac_device sac_device_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .clk_mode_i(clk_mode),
		.comparator_high_i(cmp_high), .link(link.dev), .track_input_o(track), .balance_o(),
		.cap_to_refp_o(), .conv_clk_run_o(run), .period_o(period));
	sac_host sac_host_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .free_run_i(free_run),
		.start_req_i(start_req), .read_en_i(read_en), .clear_req_i(clear_req),
		.result_valid_o(valid),
		.result_o(result), .link(link.host));
	sac_monitor sac_monitor_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.convert_start_n(link.convert_start_n), .ready_flag_clear_n(link.ready_flag_clear_n),
		.upper_byte_out_en_n(link.upper_byte_out_en_n),
		.low_bits_out_en_n(link.low_bits_out_en_n), .result_ready_flag(link.result_ready_flag),
		.data_o(link.data_o), .data_oe(link.data_oe), .period_o(period), .track_input_o(track));
	// ****************
	// helpers and scenarios
	// ****************
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// counts edges up to the next result pulse
	task automatic wait_valid(output int n);
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
			if (n > 200) begin
				errors++;
				$display("BAD %0t no result", $time);
				complete_run();
			end
		end while (valid !== 1'b1);
	endtask : wait_valid
	// first result may mix comparator levels, so judge the second
	task automatic t_free(input logic cmp, input logic [9:0] exp);
		int n;
		cmp_high = cmp;
		free_run = 1'b1;
		read_en = 1'b1;
		wait_valid(n);
		wait_valid(n);
		chk(result, exp);
		chk(link.data_bus, exp);
		chk(10'(n), 10'h00d);
		chk(link.data_oe, 10'h3ff);
		// flag fell as period two began; the host sees it one edge later
		chk(period, 4'h3);
	endtask : t_free
	// comparator follows a bit pattern, one bit per test period
	task automatic t_bits(input logic [9:0] pat);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
			if (period >= 4'h4) cmp_high = pat[4'hd - period];
		end while (n < 40);
		chk(result, pat);
		chk(link.data_bus, pat);
	endtask : t_bits
	task automatic t_clear();
		int n;
		repeat (30) @(posedge mclk_i);
		#1;
		chk(link.result_ready_flag, 1'b1);
		clear_req = 1'b1;
		@(posedge mclk_i);
		#1;
		chk(link.result_ready_flag, 1'b0);
		chk(period, 4'h2);
		clear_req = 1'b0;
		start_req = 1'b1;
		wait_valid(n);
		chk(period, 4'h3);
		start_req = 1'b0;
	endtask : t_clear
	task automatic t_off();
		read_en = 1'b0;
		repeat (6) @(posedge mclk_i);
		#1;
		chk(link.data_oe, 10'h000);
		read_en = 1'b1;
	endtask : t_off
	task automatic t_park(input sac_clk_mode_e m);
		int n;
		clk_mode = m;
		free_run = 1'b0;
		start_req = 1'b0;
		repeat (40) @(posedge mclk_i);
		#1;
		chk(period, 4'h2);
		chk(link.result_ready_flag, 1'b1);
		chk(track, 1'b1);
		if (m == sac_clk_internal) chk(run, 1'b0);
		else chk(run, 1'b1);
		start_req = 1'b1;
		wait_valid(n);
		chk(link.result_ready_flag, 1'b0);
		chk(run, 1'b1);
		start_req = 1'b0;
	endtask : t_park
	initial begin
		repeat (10) @(posedge mclk_i);
		#1 resetn_i = 1'b1;
		t_free(1'b1, 10'h3ff);
		t_free(1'b0, 10'h000);
		t_bits(10'h2a5);
		t_off();
		t_park(sac_clk_internal);
		t_park(sac_clk_external);
		t_clear();
		complete_run();
	end
endmodule : sar_adc_conversion_sequencer_test
`default_nettype wire
